// [inc/pdc_pkg.sv]
// constants, types and helpers shared by the transfer channel register block
package pdc_pkg;
  // register offsets in the channel's register space
  localparam logic [7:0]  PDC_OFS_PCI_START = 8'h40;
  localparam logic [7:0]  PDC_OFS_RAM_START = 8'h44;
  localparam logic [7:0]  PDC_OFS_CTRL      = 8'h48;
  // local memory address width (local_memory_addr_bits)
  localparam int          PDC_MEM_BITS      = 24;
  // control word field positions
  localparam int          PDC_B_ERR   = 0;
  localparam int          PDC_B_ABORT = 1;
  localparam int          PDC_B_DONE  = 2;
  localparam int          PDC_B_DIR   = 3;
  localparam int          PDC_B_REQ   = 4;
  localparam int          PDC_B_EN    = 5;
  localparam int          PDC_B_IACT  = 6;
  localparam int          PDC_B_IEN   = 7;
  localparam int          PDC_B_XSTAT = 8;
  localparam int          PDC_B_XEN   = 9;
  localparam int          PDC_B_RCV   = 10;
  localparam int          PDC_LEN_LO  = 16;
  localparam int          PDC_LEN_HI  = 27;
  // reset values
  localparam logic [29:0] PDC_RST_PCI   = 30'h0000_0000;
  localparam logic [21:0] PDC_RST_RAM   = 22'h00_0000;
  localparam logic [9:0]  PDC_RST_LEN   = 10'h000;
  localparam logic [31:0] PDC_RST_RDATA = 32'h0000_0000;
  // byte and word counts
  localparam logic [12:0] PDC_WORD_BYTES = 13'h0004;
  localparam logic [12:0] PDC_MAX_BYTES  = 13'h1000;
  localparam logic [10:0] PDC_MAX_WORDS  = 11'h400;

  // channel state, one-hot
  typedef enum logic [1:0] {
    PDC_ST_IDLE = 2'b01,
    PDC_ST_RUN  = 2'b10
  } pdc_state_e;

  // request handed to the bus master
  typedef struct packed {
    logic        req;
    logic        dir;
    logic [31:0] addr;
    logic [10:0] words;
  } pdc_mreq_s;

  // one word in the data path, with last-word marker
  typedef struct packed {
    logic        last;
    logic [31:0] data;
  } pdc_word_s;

  // length field to bytes; zero means the maximum transfer
  function automatic logic [12:0] pdc_len_bytes(input logic [9:0] len_words);
    pdc_len_bytes = (len_words == 10'h000) ? PDC_MAX_BYTES : {1'b0, len_words, 2'b00};
  endfunction : pdc_len_bytes

  // length field to words
  function automatic logic [10:0] pdc_len_words(input logic [9:0] len_words);
    pdc_len_words = (len_words == 10'h000) ? PDC_MAX_WORDS : {1'b0, len_words};
  endfunction : pdc_len_words
endpackage : pdc_pkg

// [rtl/pdc_buf2.sv]
// two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ns
module pdc_buf2
  import pdc_pkg::*;
(
  input  wire logic      mclk,      // clock
  input  wire logic      rst_b,     // async reset, active low
  input  wire logic      flush,     // drop all held words
  input  wire logic      in_valid,  // word offered
  output logic           in_ready,  // room for a word
  input  wire pdc_word_s in_data,   // offered word
  output logic           out_valid, // word held
  input  wire logic      out_ready, // sink takes word
  output pdc_word_s      out_data   // oldest word, from a register
);
  pdc_word_s  mem_q [2];
  pdc_word_s  mem_d [2];
  logic       wp_q, wp_d, rp_q, rp_d;
  logic [1:0] cnt_q, cnt_d;
  logic       push, pop;

  // handshakes come straight from the fill count
  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // next pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (flush) begin
      wp_d  = 1'b0;
      rp_d  = 1'b0;
      cnt_d = 2'd0;
    end else begin
      if (push) begin
        mem_d[wp_q] = in_data;
        wp_d        = ~wp_q;
      end
      if (pop) begin
        rp_d = ~rp_q;
      end
      cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // register stage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'd0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : pdc_buf2

// [rtl/pdc_channel.sv]
// transfer channel: start address, local address and control registers with data path
`timescale 1ns/1ns
module pdc_channel
  import pdc_pkg::*;
(
  input  wire logic        mclk,              // clock, 25 MHz
  input  wire logic        rst_b,             // async reset, active low
  input  wire logic        io_map_sel,        // 1: registers in io window
  input  wire logic        acc_valid,         // register access strobe
  input  wire logic        acc_write,         // 1 write, 0 read
  input  wire logic        acc_io_space,      // access comes through io window
  input  wire logic [7:0]  acc_addr,          // byte offset
  input  wire logic [31:0] acc_wdata,         // write data
  output logic             acc_hit,           // access decodes to a register
  output logic [31:0]      acc_rdata_q,       // read data, next cycle
  output pdc_mreq_s        mst_req,           // request to bus master
  output logic             mst_recovery_en,   // data recovery enable
  input  wire logic        mst_master_abort,  // master abort pulse
  input  wire logic        mst_target_abort,  // target abort pulse
  input  wire logic        rta_clr,           // clear received target abort
  output logic             rta_q,             // received target abort status
  input  wire logic        pm_rx_valid,       // word read from pci
  input  wire logic [31:0] pm_rx_data,        // that word
  output logic             pm_rx_ready,       // word taken
  output logic             pm_tx_valid,       // word to write to pci
  output logic [31:0]      pm_tx_data,        // that word
  input  wire logic        pm_tx_ready,       // master takes it
  output logic [23:0]      ram_addr_q,        // local byte address
  output logic             ram_rd_req,        // local read, data same cycle
  input  wire logic        ram_rd_valid,      // local read data valid
  input  wire logic [31:0] ram_rd_data,       // local read data
  output logic             ram_wr_valid,      // local write request
  output logic [31:0]      ram_wr_data,       // local write data
  input  wire logic        ram_wr_ready,      // local write taken
  input  wire logic        external_interrupt_in_n, // external interrupt, active low
  output logic             int_line_n_q       // interrupt line, active low
);
  pdc_state_e  st_q, st_d;
  logic [29:0] pci_q, pci_d;
  logic [21:0] ram_start_q, ram_start_d, ram_cur_q, ram_cur_d;
  logic [9:0]  len_q, len_d;
  logic [12:0] rem_q, rem_d;
  logic [10:0] left_q, left_d;
  logic        err_q, err_d, done_q, done_d, dir_q, dir_d, req_q, req_d;
  logic        en_q, en_d, iact_q, iact_d, ien_q, ien_d, xstat_q, xstat_d;
  logic        xen_q, xen_d, rcv_q, rcv_d, rta_d, int_n_d;
  logic [31:0] rdata_d;
  logic        run, active, wr_pci, wr_ram, wr_ctrl, start, abort, flush;
  logic        src_valid, snk_ready, src_fire, snk_fire;
  logic        buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  pdc_word_s   buf_in, buf_out;
  logic [31:0] ctrl_view;

  // register decode; window chosen by mapping option
  assign acc_hit = acc_valid & (acc_io_space == io_map_sel) &
                   (acc_addr == PDC_OFS_PCI_START || acc_addr == PDC_OFS_RAM_START ||
                    acc_addr == PDC_OFS_CTRL);
  assign wr_pci  = acc_hit & acc_write & (acc_addr == PDC_OFS_PCI_START);
  assign wr_ram  = acc_hit & acc_write & (acc_addr == PDC_OFS_RAM_START);
  assign wr_ctrl = acc_hit & acc_write & (acc_addr == PDC_OFS_CTRL);
  assign run     = (st_q == PDC_ST_RUN);
  assign active  = run & en_q;
  assign abort   = wr_ctrl & acc_wdata[PDC_B_ABORT];
  assign start   = wr_ctrl & acc_wdata[PDC_B_REQ] & acc_wdata[PDC_B_EN] &
                   ~acc_wdata[PDC_B_ABORT] & ~run;
  assign flush   = run & (abort | mst_master_abort | mst_target_abort);

  // data path steered by direction, gated by enable
  assign src_valid     = dir_q ? pm_rx_valid : ram_rd_valid;
  assign buf_in_valid  = active & (left_q != 11'd0) & src_valid;
  assign pm_rx_ready   = active & dir_q & (left_q != 11'd0) & buf_in_ready;
  assign ram_rd_req    = active & ~dir_q & (left_q != 11'd0) & buf_in_ready;
  assign buf_in.data   = dir_q ? pm_rx_data : ram_rd_data;
  assign buf_in.last   = (left_q == 11'd1);
  assign src_fire      = buf_in_valid & buf_in_ready;
  assign snk_ready     = dir_q ? ram_wr_ready : pm_tx_ready;
  assign buf_out_ready = active & snk_ready;
  assign snk_fire      = buf_out_valid & buf_out_ready;
  assign ram_wr_valid  = active & dir_q & buf_out_valid;
  assign pm_tx_valid   = active & ~dir_q & buf_out_valid;
  assign ram_wr_data   = buf_out.data;
  assign pm_tx_data    = buf_out.data;

  // buffer between source and sink
  pdc_buf2 u_buf (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .flush     (flush),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out)
  );

  // master request and recovery control
  assign mst_req.req     = active;
  assign mst_req.dir     = dir_q;
  assign mst_req.addr    = {pci_q, 2'b00};
  assign mst_req.words   = pdc_len_words(len_q);
  assign mst_recovery_en = rcv_q;

  // control word view; reserved and abort bits read zero
  always_comb begin
    ctrl_view                 = 32'h0000_0000;
    ctrl_view[PDC_B_ERR]      = err_q;
    ctrl_view[PDC_B_DONE]     = done_q;
    ctrl_view[PDC_B_DIR]      = dir_q;
    ctrl_view[PDC_B_REQ]      = req_q;
    ctrl_view[PDC_B_EN]       = en_q;
    ctrl_view[PDC_B_IACT]     = iact_q;
    ctrl_view[PDC_B_IEN]      = ien_q;
    ctrl_view[PDC_B_XSTAT]    = xstat_q;
    ctrl_view[PDC_B_XEN]      = xen_q;
    ctrl_view[PDC_B_RCV]      = rcv_q;
    ctrl_view[PDC_LEN_HI:PDC_LEN_LO] = run ? rem_q[11:0] : {len_q, 2'b00};
  end

  // read data; unmapped offsets read zero
  always_comb begin
    rdata_d = acc_rdata_q;
    if (acc_valid && !acc_write) begin
      rdata_d = 32'h0000_0000;
      if (acc_hit) begin
        unique case (acc_addr)
          PDC_OFS_PCI_START: rdata_d = {pci_q, 2'b00};
          PDC_OFS_RAM_START: rdata_d = {8'h00, run ? ram_cur_q : ram_start_q, 2'b00};
          default:           rdata_d = ctrl_view;
        endcase
      end
    end
  end

  // next state of registers and channel
  always_comb begin
    st_d        = st_q;
    pci_d       = pci_q;
    ram_start_d = ram_start_q;
    ram_cur_d   = ram_cur_q;
    len_d       = len_q;
    rem_d       = rem_q;
    left_d      = left_q;
    err_d       = err_q;
    done_d      = done_q;
    dir_d       = dir_q;
    req_d       = req_q;
    en_d        = en_q;
    iact_d      = iact_q;
    ien_d       = ien_q;
    xstat_d     = xstat_q;
    xen_d       = xen_q;
    rcv_d       = rcv_q;
    rta_d       = rta_q;
    if (wr_pci && !run) pci_d = acc_wdata[31:2];
    if (wr_ram && !run) ram_start_d = acc_wdata[PDC_MEM_BITS-1:2];
    if (wr_ctrl) begin
      en_d  = acc_wdata[PDC_B_EN];
      ien_d = acc_wdata[PDC_B_IEN];
      xen_d = acc_wdata[PDC_B_XEN];
      rcv_d = acc_wdata[PDC_B_RCV];
      if (!run) begin
        dir_d = acc_wdata[PDC_B_DIR];
        len_d = acc_wdata[PDC_LEN_HI:PDC_LEN_LO+2];
      end
      if (acc_wdata[PDC_B_ERR])   err_d   = 1'b0;
      if (acc_wdata[PDC_B_IACT])  iact_d  = 1'b0;
      if (acc_wdata[PDC_B_XSTAT]) xstat_d = 1'b0;
    end
    if (rta_clr) rta_d = 1'b0;
    unique case (st_q)
      PDC_ST_IDLE: begin
        if (start) begin
          st_d      = PDC_ST_RUN;
          req_d     = 1'b1;
          done_d    = 1'b0;
          ram_cur_d = ram_start_q;
          rem_d     = pdc_len_bytes(acc_wdata[PDC_LEN_HI:PDC_LEN_LO+2]);
          left_d    = pdc_len_words(acc_wdata[PDC_LEN_HI:PDC_LEN_LO+2]);
        end
      end
      PDC_ST_RUN: begin
        if (src_fire) left_d = left_q - 11'd1;
        if ((src_fire && !dir_q) || (snk_fire && dir_q)) ram_cur_d = ram_cur_q + 22'd1;
        if (snk_fire) rem_d = rem_q - PDC_WORD_BYTES;
        if (abort) begin
          st_d  = PDC_ST_IDLE;
          req_d = 1'b0;
        end else if (mst_master_abort) begin
          st_d   = PDC_ST_IDLE;
          req_d  = 1'b0;
          err_d  = 1'b1;
          iact_d = 1'b1;
        end else if (mst_target_abort) begin
          st_d   = PDC_ST_IDLE;
          req_d  = 1'b0;
          rta_d  = 1'b1;
          iact_d = 1'b1;
        end else if (snk_fire && rem_q == PDC_WORD_BYTES) begin
          st_d   = PDC_ST_IDLE;
          req_d  = 1'b0;
          done_d = 1'b1;
          iact_d = 1'b1;
        end
      end
    endcase
    if (xen_q && !external_interrupt_in_n) xstat_d = 1'b1;
  end

  // interrupt line, low when an enabled source is active
  assign int_n_d = ~((iact_q & ien_q) | (xstat_q & xen_q));

  // register stage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q         <= PDC_ST_IDLE;
      pci_q        <= PDC_RST_PCI;
      ram_start_q  <= PDC_RST_RAM;
      ram_cur_q    <= PDC_RST_RAM;
      len_q        <= PDC_RST_LEN;
      rem_q        <= 13'h0000;
      left_q       <= 11'h000;
      {err_q, done_q, dir_q, req_q, en_q, iact_q} <= 6'h00;
      {ien_q, xstat_q, xen_q, rcv_q, rta_q}       <= 5'h00;
      int_line_n_q <= 1'b1;
      acc_rdata_q  <= PDC_RST_RDATA;
    end else begin
      st_q         <= st_d;
      pci_q        <= pci_d;
      ram_start_q  <= ram_start_d;
      ram_cur_q    <= ram_cur_d;
      len_q        <= len_d;
      rem_q        <= rem_d;
      left_q       <= left_d;
      {err_q, done_q, dir_q, req_q, en_q, iact_q} <= {err_d, done_d, dir_d, req_d, en_d, iact_d};
      {ien_q, xstat_q, xen_q, rcv_q, rta_q}       <= {ien_d, xstat_d, xen_d, rcv_d, rta_d};
      int_line_n_q <= int_n_d;
      acc_rdata_q  <= rdata_d;
    end
  end

  // local address output follows the working address
  assign ram_addr_q = {ram_cur_q, 2'b00};

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_start;  start; endsequence
  sequence s_finish; snk_fire && rem_q == PDC_WORD_BYTES && !abort &&
                     !mst_master_abort && !mst_target_abort; endsequence
  sequence s_rd(logic [7:0] a); acc_hit && !acc_write && acc_addr == a; endsequence

  property p_pci_low; s_rd(PDC_OFS_PCI_START) |=> acc_rdata_q[1:0] == 2'b00; endproperty
  a_pci_low: assert property (p_pci_low) else $error("pci start low bits not zero");
  property p_pci_hold; run && wr_pci |=> $stable(pci_q); endproperty
  a_pci_hold: assert property (p_pci_hold) else $error("pci start changed in run");
  property p_ram_step; run && dir_q && snk_fire && !abort |=> ram_cur_q == $past(ram_cur_q) + 22'd1; endproperty
  a_ram_step: assert property (p_ram_step) else $error("local address did not step");
  property p_ram_hi; s_rd(PDC_OFS_RAM_START) |=> acc_rdata_q[31:24] == 8'h00; endproperty
  a_ram_hi: assert property (p_ram_hi) else $error("local address high bits set");
  property p_err; run && mst_master_abort && !abort |=> err_q && iact_q && !req_q; endproperty
  a_err: assert property (p_err) else $error("master abort not flagged");
  property p_abort; run && abort |=> !req_q ##0 st_q == PDC_ST_IDLE; endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop");
  property p_ctrl_rd; s_rd(PDC_OFS_CTRL) |=> !acc_rdata_q[PDC_B_ABORT] &&
    acc_rdata_q[15:11] == 5'h00 && acc_rdata_q[31:28] == 4'h0; endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("reserved or abort bit read one");
  property p_start; s_start |=> req_q && !done_q; endproperty
  a_start: assert property (p_start) else $error("request did not start");
  property p_finish; s_finish |=> done_q && iact_q && !req_q; endproperty
  a_finish: assert property (p_finish) else $error("completion not flagged");
  property p_dir; active && buf_out_valid |-> ram_wr_valid == dir_q && pm_tx_valid == !dir_q; endproperty
  a_dir: assert property (p_dir) else $error("wrong data path");
  property p_en; !en_q |-> !buf_in_valid && !ram_wr_valid && !pm_tx_valid; endproperty
  a_en: assert property (p_en) else $error("data moved while disabled");
  property p_count; run && snk_fire |=> rem_q == $past(rem_q) - PDC_WORD_BYTES; endproperty
  a_count: assert property (p_count) else $error("length did not count down");
  property p_max; start && (acc_wdata[PDC_LEN_HI:PDC_LEN_LO+2] == 10'h000) |=>
    rem_q == PDC_MAX_BYTES; endproperty
  a_max: assert property (p_max) else $error("zero length not maximum");
  property p_line; 1'b1 |=> int_line_n_q == !(($past(iact_q) && $past(ien_q)) ||
    ($past(xstat_q) && $past(xen_q))); endproperty
  a_line: assert property (p_line) else $error("interrupt line wrong");
  property p_ext; xen_q && !external_interrupt_in_n |=> xstat_q ##1 !int_line_n_q; endproperty
  a_ext: assert property (p_ext) else $error("external interrupt missed");
  property p_noreq; !run && wr_ctrl && !acc_wdata[PDC_B_EN] |=> !req_q && !run; endproperty
  a_noreq: assert property (p_noreq) else $error("request taken while disabled");
endmodule : pdc_channel

// [dv/pdc_far_model.sv]
// far-side model: pci master data ports and local memory
`timescale 1ns/1ns
module pdc_far_model
  import pdc_pkg::*;
(
  input  wire logic        mclk,         // clock
  input  wire logic        rst_b,        // reset, active low
  input  wire pdc_mreq_s   mst_req,      // channel request
  input  wire logic [15:0] hold_at,      // stall local writes at this count
  input  wire logic        tx_hold,      // stall all sinks
  output logic             pm_rx_valid,  // word from pci
  output logic [31:0]      pm_rx_data,   // that word
  input  wire logic        pm_rx_ready,  // taken
  input  wire logic        pm_tx_valid,  // word to pci
  input  wire logic [31:0] pm_tx_data,   // that word
  output logic             pm_tx_ready,  // pci takes it
  input  wire logic [23:0] ram_addr_q,   // local address
  input  wire logic        ram_rd_req,   // local read
  output logic             ram_rd_valid, // read data valid
  output logic [31:0]      ram_rd_data,  // read data
  input  wire logic        ram_wr_valid, // local write
  input  wire logic [31:0] ram_wr_data,  // write data
  output logic             ram_wr_ready, // write taken
  output logic [15:0]      wr_cnt_q,     // local writes seen
  output logic [15:0]      tx_cnt_q,     // pci writes seen
  output logic [31:0]      wr_last_q,    // last local write data
  output logic [23:0]      wa_last_q,    // last local write address
  output logic [31:0]      tx_last_q     // last pci write data
);
  logic [15:0] rx_cnt_q;
  // sources offer marked words; idle lines show the inverse
  assign pm_rx_valid  = mst_req.req & mst_req.dir;
  assign pm_rx_data   = pm_rx_valid ? {16'hC300, rx_cnt_q} : ~{16'hC300, rx_cnt_q};
  assign ram_rd_valid = ram_rd_req;
  assign ram_rd_data  = ram_rd_req ? {8'h5A, ram_addr_q} : ~{8'h5A, ram_addr_q};
  assign ram_wr_ready = !tx_hold && (wr_cnt_q != hold_at);
  assign pm_tx_ready  = !tx_hold;
  // record what reaches each sink
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {rx_cnt_q, wr_cnt_q, tx_cnt_q, wr_last_q, wa_last_q, tx_last_q} <= '0;
    end else begin
      if (pm_rx_valid && pm_rx_ready) rx_cnt_q <= rx_cnt_q + 16'h0001;
      if (ram_wr_valid && ram_wr_ready) begin
        wr_cnt_q  <= wr_cnt_q + 16'h0001;
        wr_last_q <= ram_wr_data;
        wa_last_q <= ram_addr_q;
      end
      if (pm_tx_valid && pm_tx_ready) begin
        tx_cnt_q  <= tx_cnt_q + 16'h0001;
        tx_last_q <= pm_tx_data;
      end
    end
  end
endmodule : pdc_far_model

// [dv/pci_dma_channel_registers_tb.sv]
// self-checking bench for the transfer channel
`timescale 1ns/1ns
module pci_dma_channel_registers_tb;
  import pdc_pkg::*;
  logic mclk = 0, rst_b = 0, sp = 0, av = 0, aw = 0, hit, ma = 0, ta = 0, rc = 0, rta, xn = 1;
  logic [7:0] aa = 0;
  logic [31:0] wd = 0, rdq, rxd, txd, rdd, wrd, wl, tl;
  logic rxv, rxr, txv, txr, rrq, rdv, wrv, wrr, rec, intn, th = 0, ms = 0;
  logic [15:0] ha = 16'hFFFF, wc, tc;
  logic [23:0] ra, wa;
  pdc_mreq_s mreq;
  int err_count = 0, tests_run = 0;
  always #20 mclk = ~mclk;
  pdc_channel DUT (.mclk(mclk), .rst_b(rst_b), .io_map_sel(ms), .acc_valid(av),
    .acc_write(aw), .acc_io_space(sp), .acc_addr(aa), .acc_wdata(wd), .acc_hit(hit),
    .acc_rdata_q(rdq), .mst_req(mreq), .mst_recovery_en(rec), .mst_master_abort(ma),
    .mst_target_abort(ta), .rta_clr(rc), .rta_q(rta), .pm_rx_valid(rxv), .pm_rx_data(rxd),
    .pm_rx_ready(rxr), .pm_tx_valid(txv), .pm_tx_data(txd), .pm_tx_ready(txr),
    .ram_addr_q(ra), .ram_rd_req(rrq), .ram_rd_valid(rdv), .ram_rd_data(rdd),
    .ram_wr_valid(wrv), .ram_wr_data(wrd), .ram_wr_ready(wrr),
    .external_interrupt_in_n(xn), .int_line_n_q(intn));
  pdc_far_model far (.mclk(mclk), .rst_b(rst_b), .mst_req(mreq), .hold_at(ha), .tx_hold(th),
    .pm_rx_valid(rxv), .pm_rx_data(rxd), .pm_rx_ready(rxr), .pm_tx_valid(txv),
    .pm_tx_data(txd), .pm_tx_ready(txr), .ram_addr_q(ra), .ram_rd_req(rrq),
    .ram_rd_valid(rdv), .ram_rd_data(rdd), .ram_wr_valid(wrv), .ram_wr_data(wrd),
    .ram_wr_ready(wrr), .wr_cnt_q(wc), .tx_cnt_q(tc), .wr_last_q(wl), .wa_last_q(wa),
    .tx_last_q(tl));
  // verdict and end of run
  task automatic test_done();
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one register access; returns hit and read data
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic h, output logic [31:0] r);
    @(posedge mclk);
    av <= 1'b1;
    aw <= w;
    aa <= a;
    wd <= d;
    #1 h = hit;
    @(posedge mclk);
    av <= 1'b0;
    #1 r = rdq;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic h;
    logic [31:0] r;
    acc(1'b1, a, d, h, r);
  endtask : wr
  // masked read compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic h;
    logic [31:0] r;
    acc(1'b0, a, 32'h0, h, r);
    chk(h, 1'b1);
    chk(r & m, e);
  endtask : rd
  // bounded wait for the request bit to drop
  task automatic wait_idle();
    int i;
    for (i = 0; i < 3000 && mreq.req !== 1'b0; i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 3000) begin
      err_count++;
      test_done();
    end
  endtask : wait_idle
  // main sequence
  initial begin
    logic h;
    logic [31:0] r;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rd(8'h40, 0, '1); rd(8'h44, 0, '1); rd(8'h48, 0, '1);
    @(posedge mclk);
    sp <= 1'b1;
    acc(1'b0, 8'h48, 0, h, r); chk(h, 0); chk(r, 0);
    @(posedge mclk);
    ms <= 1'b1;
    rd(8'h48, 0, '1);
    @(posedge mclk);
    ms <= 1'b0;
    sp <= 1'b0;
    acc(1'b0, 8'h4C, 0, h, r); chk(h, 0); chk(r, 0);
    wr(8'h40, '1); rd(8'h40, 32'hFFFF_FFFC, '1);
    wr(8'h44, '1); rd(8'h44, 32'h00FF_FFFC, '1);
    wr(8'h48, 32'hF003_F800); rd(8'h48, 0, '1);
    wr(8'h48, 32'h0010_0010); rd(8'h48, 32'h0010_0000, '1); chk(wc, 0);
    // four-word pci to local move, stalled after two words; software keeps four words
    wr(8'h40, 32'h1000); wr(8'h44, 32'h100); ha <= 16'h2;
    wr(8'h48, 32'h0010_0038); repeat (20) @(posedge mclk);
    rd(8'h48, 32'h0008_0038, '1); rd(8'h44, 32'h108, '1);
    chk(mreq.addr, 32'h1000); chk(mreq.words, 4); chk(mreq.dir, 1);
    wr(8'h40, 32'h2222); ha <= 16'hFFFF;
    wait_idle(); rd(8'h48, 32'h0010_006C, '1);
    rd(8'h40, 32'h1000, '1); rd(8'h44, 32'h100, '1);
    chk(wc, 4); chk(wa, 24'h10C); chk(wl, 32'hC300_0003); chk(intn, 1);
    wr(8'h48, 32'h0010_00A0); repeat (3) @(posedge mclk); chk(intn, 0);
    wr(8'h48, 32'h0010_00E0); repeat (3) @(posedge mclk); chk(intn, 1);
    rd(8'h48, 32'h0010_00A4, '1);
    // local to pci move
    wr(8'h44, 32'h200); wr(8'h48, 32'h0010_0030); rd(8'h48, 0, 32'h4); wait_idle();
    chk(tc, 4); chk(tl, 32'h5A00_020C);
    // abort in mid-transfer
    th <= 1'b1; wr(8'h48, 32'h0010_0030); repeat (10) @(posedge mclk);
    wr(8'h48, 32'h0000_0022); rd(8'h48, 0, 32'h12); th <= 1'b0;
    repeat (10) @(posedge mclk); chk(tc, 4);
    // master abort sets error and interrupt-active
    th <= 1'b1; wr(8'h48, 32'h0010_0030); repeat (10) @(posedge mclk);
    @(posedge mclk);
    ma <= 1'b1;
    @(posedge mclk);
    ma <= 1'b0;
    wait_idle(); th <= 1'b0; rd(8'h48, 32'h41, 32'h41);
    wr(8'h48, 32'h0000_0061); rd(8'h48, 0, 32'h41);
    // external interrupt, disabled then enabled
    @(posedge mclk);
    xn <= 1'b0;
    repeat (3) @(posedge mclk);
    xn <= 1'b1;
    rd(8'h48, 0, 32'h100); chk(intn, 1);
    wr(8'h48, 32'h0000_0620); chk(rec, 1);
    @(posedge mclk);
    xn <= 1'b0;
    @(posedge mclk);
    xn <= 1'b1;
    rd(8'h48, 32'h100, 32'h100);
    repeat (2) @(posedge mclk); chk(intn, 0);
    wr(8'h48, 32'h0000_0720); rd(8'h48, 0, 32'h100);
    // target abort during a stalled local to pci move
    th <= 1'b1; wr(8'h48, 32'h0010_0030); repeat (4) @(posedge mclk);
    ta <= 1'b1;
    @(posedge mclk);
    ta <= 1'b0;
    wait_idle(); th <= 1'b0; chk(rta, 1); rd(8'h48, 32'h40, 32'h41);
    @(posedge mclk);
    rc <= 1'b1;
    @(posedge mclk);
    rc <= 1'b0;
    @(posedge mclk);
    chk(rta, 0);
    // zero length moves the maximum
    wr(8'h44, 0); wr(8'h48, 32'h0000_0038); wait_idle(); chk(wc, 1028);
    test_done();
  end
endmodule : pci_dma_channel_registers_tb
